/* src/mdrp_pkg.sv */
/*
  Shared constants of the multiplexed dynamic memory port controller:
  address split, strobe timing in nanoseconds and the cycle counts derived
  from them. Assumes a single 20 MHz clock.
*/
`default_nettype none

package mdrp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_BITS     = 14;  // full cell address
  localparam int ROW_BITS      = 7;   // shared address lines
  localparam int ROW_LSB       = 7;   // row half sits in the upper bits
  localparam int ROWS_FULL     = 128; // rows refreshed with column strobe high
  localparam int ROWS_CBR      = 64;  // rows refreshed with column strobe low

  // ---------------------------------------------------------------
  // timing in nanoseconds
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 50;
  localparam int PRECHARGE_INTERVAL_NS  = 100;
  localparam int ROW_ACTIVE_MIN_TIME_NS = 150;
  localparam int ROW_ADDR_HOLD_NS       = 25;
  localparam int COL_ACCESS_NS          = 100;
  localparam int ROW_TO_COL_DELAY_NS    = 50;  // latest column strobe fall
  localparam int MUX_WINDOW_NS          = 40;
  localparam int RETENTION_NS           = 2000000;

  // least times round up to whole cycles, never below one
  function automatic int mdrp_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ---------------------------------------------------------------
  // derived cycle counts
  // ---------------------------------------------------------------
  localparam int PRECHARGE_CYC  = mdrp_min_cyc(PRECHARGE_INTERVAL_NS);
  localparam int ROW_ACTIVE_CYC = mdrp_min_cyc(ROW_ACTIVE_MIN_TIME_NS);
  localparam int ROW_HOLD_CYC   = mdrp_min_cyc(ROW_ADDR_HOLD_NS);
  localparam int COL_ACCESS_CYC = mdrp_min_cyc(COL_ACCESS_NS);

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MDRP_IDLE,
    MDRP_ROW,
    MDRP_HOLD,
    MDRP_COL,
    MDRP_CAS,
    MDRP_REF,
    MDRP_PRE,
    MDRP_DESEL
  } mdrp_state_t;

endpackage

`default_nettype wire

/* src/mdrp_refresh_if.sv */
/*
  Handshake between the refresh timer and the access sequencer.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface mdrp_refresh_if;
  logic       req;  // refresh due, level until ack
  logic       ack;  // one-cycle pulse when the refresh starts
  logic [6:0] row;  // row to refresh next

  modport timer (output req, output row, input  ack);
  modport ctrl  (input  req, input  row, output ack);
endinterface

`default_nettype wire

/* src/mdrp_refresh_timer.sv */
/*
  Refresh timer: raises a request every interval and steps the refresh row
  on each acknowledge. Assumes the sequencer acknowledges within one access.
*/
`default_nettype none

module mdrp_refresh_timer #(
  parameter int INTERVAL_CYC = 312,
  parameter int ROW_COUNT    = 128
) (
  input  wire logic     clk_in,
  input  wire logic     srst_in,
  mdrp_refresh_if.timer rif
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (INTERVAL_CYC < 16 || ROW_COUNT < 1 || ROW_COUNT > 128)
  begin : g_chk
    $error("refresh timer parameters out of range");
  end

  logic [31:0] tick;
  logic [31:0] since_ack;

  // ---------------------------------------------------------------
  // interval counter and request flag
  // ---------------------------------------------------------------
  // the set wins over the ack so a tick landing on it is kept
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tick    <= 32'h0;
      rif.req <= 1'b0;
    end
    else
    begin
      if (tick == 32'(INTERVAL_CYC - 1))
      begin
        tick    <= 32'h0;
        rif.req <= 1'b1;
      end
      else
      begin
        tick <= tick + 32'h1;
        if (rif.ack)
          rif.req <= 1'b0;
      end
    end
  end

  // row pointer wraps at the row count
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rif.row <= 7'h00;
    else if (rif.ack)
      rif.row <= (rif.row == 7'(ROW_COUNT - 1)) ? 7'h00 : rif.row + 7'h01;
  end

  // ---------------------------------------------------------------
  // checking helper
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in || rif.ack)
      since_ack <= 32'h0;
    else if (since_ack != 32'hffffffff)
      since_ack <= since_ack + 32'h1;
  end

  a_refresh_period: assert property (@(posedge clk_in) disable iff (srst_in)
    since_ack < 32'(2 * INTERVAL_CYC + 64))
    else $error("refresh not started within two intervals");

endmodule

`default_nettype wire

/* src/mdrp_ctrl.sv */
/*
  Controller for a 16384 x 1 dynamic memory with multiplexed address lines:
  takes single-bit read and write requests, drives the row and column
  strobes, write strobe, address multiplexer and data input, and schedules
  refresh. Assumes the memory's data output arrives synchronous to clk_in.

*/
`default_nettype none

module mdrp_ctrl #(
  parameter int RETENTION_NS   = mdrp_pkg::RETENTION_NS,
  parameter bit CBR_REFRESH    = 1'b0, // refresh with column strobe low first
  parameter bit RELEASE_ON_FALL = 1'b0 // memory releases output on column fall
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [13:0] req_addr_in,
  input  wire logic        req_wdata_in,
  output var  logic        req_ready_out,
  output var  logic        rd_valid_out,
  output var  logic        rd_data_out,
  output var  logic        ram_ras_n_out,
  output var  logic        ram_cas_n_out,
  output var  logic        ram_we_n_out,
  output var  logic [6:0]  ram_addr_out,
  output var  logic        ram_din_out,
  input  wire logic        ram_dout_in
);

  // ---------------------------------------------------------------
  // derived figures and checks
  // ---------------------------------------------------------------
  // longest time, so rounds down
  localparam int INTERVAL_CYC = RETENTION_NS / mdrp_pkg::CLK_PERIOD_NS
                                / (CBR_REFRESH ? mdrp_pkg::ROWS_CBR : mdrp_pkg::ROWS_FULL);

  if (INTERVAL_CYC < 16 || mdrp_pkg::COL_ACCESS_CYC > 14 || mdrp_pkg::ROW_ACTIVE_CYC > 14
      || mdrp_pkg::PRECHARGE_CYC > 14)
  begin : g_chk
    $error("retention or timing figures outside what the sequencer can serve");
  end

  mdrp_pkg::mdrp_state_t state;
  logic [3:0]            cnt;
  logic [3:0]            ras_cnt;
  logic                  is_write;
  logic                  is_ref;
  logic [6:0]            col_addr;
  logic                  desel_due;

  mdrp_refresh_if rif ();

  // ---------------------------------------------------------------
  // refresh timer
  // ---------------------------------------------------------------
  mdrp_refresh_timer #(
    .INTERVAL_CYC (INTERVAL_CYC),
    .ROW_COUNT    (CBR_REFRESH ? mdrp_pkg::ROWS_CBR : mdrp_pkg::ROWS_FULL)
  ) u_refresh (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .rif     (rif.timer)
  );

  // ---------------------------------------------------------------
  // row strobe low-time counter
  // ---------------------------------------------------------------
  // saturates so long cycles never wrap into a false short count
  always_ff @(posedge clk_in)
  begin
    if (srst_in || ram_ras_n_out)
      ras_cnt <= 4'h0;
    else if (ras_cnt != 4'hf)
      ras_cnt <= ras_cnt + 4'h1;
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state         <= mdrp_pkg::MDRP_IDLE;
      cnt           <= 4'h0;
      is_write      <= 1'b0;
      is_ref        <= 1'b0;
      col_addr      <= 7'h00;
      desel_due     <= 1'b0;
      req_ready_out <= 1'b0;
      rd_valid_out  <= 1'b0;
      rd_data_out   <= 1'b0;
      ram_ras_n_out <= 1'b1;
      ram_cas_n_out <= 1'b1;
      ram_we_n_out  <= 1'b1;
      ram_addr_out  <= 7'h00;
      ram_din_out   <= 1'b0;
      rif.ack       <= 1'b0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      rif.ack      <= 1'b0;
      case (state)
        mdrp_pkg::MDRP_IDLE:
        begin
          if (req_ready_out && req_valid_in)
          begin
            // row half goes out a full cycle before the row strobe falls
            ram_addr_out  <= req_addr_in[13:mdrp_pkg::ROW_LSB];
            col_addr      <= req_addr_in[6:0];
            is_write      <= req_write_in;
            ram_din_out   <= req_wdata_in;
            is_ref        <= 1'b0;
            req_ready_out <= 1'b0;
            state         <= mdrp_pkg::MDRP_ROW;
          end
          else if (rif.req)
          begin
            ram_addr_out  <= rif.row;
            ram_cas_n_out <= ~CBR_REFRESH;
            is_ref        <= 1'b1;
            rif.ack       <= 1'b1;
            req_ready_out <= 1'b0;
            state         <= mdrp_pkg::MDRP_ROW;
          end
          else
            req_ready_out <= 1'b1;
        end
        mdrp_pkg::MDRP_ROW:
        begin
          ram_ras_n_out <= 1'b0;
          state         <= mdrp_pkg::MDRP_HOLD;
        end
        mdrp_pkg::MDRP_HOLD:
        begin
          // row hold of one cycle already past; switch the multiplexer now
          if (is_ref)
            state <= mdrp_pkg::MDRP_REF;
          else
          begin
            ram_addr_out <= col_addr;
            ram_we_n_out <= ~is_write;
            state        <= mdrp_pkg::MDRP_COL;
          end
        end
        mdrp_pkg::MDRP_COL:
        begin
          ram_cas_n_out <= 1'b0;
          cnt           <= 4'h0;
          state         <= mdrp_pkg::MDRP_CAS;
        end
        mdrp_pkg::MDRP_CAS:
        begin
          cnt <= cnt + 4'h1;
          // data sampled while both strobes are still low, so turn-off never bites
          if (cnt >= 4'(mdrp_pkg::COL_ACCESS_CYC - 1) && ras_cnt >= 4'(mdrp_pkg::ROW_ACTIVE_CYC - 1))
          begin
            rd_valid_out  <= ~is_write;
            rd_data_out   <= ram_dout_in;
            ram_ras_n_out <= 1'b1;
            ram_cas_n_out <= 1'b1;
            ram_we_n_out  <= 1'b1;
            desel_due     <= RELEASE_ON_FALL & ~is_write;
            cnt           <= 4'h0;
            state         <= mdrp_pkg::MDRP_PRE;
          end
        end
        mdrp_pkg::MDRP_REF:
        begin
          if (ras_cnt >= 4'(mdrp_pkg::ROW_ACTIVE_CYC - 1))
          begin
            ram_ras_n_out <= 1'b1;
            ram_cas_n_out <= 1'b1;
            cnt           <= 4'h0;
            state         <= mdrp_pkg::MDRP_PRE;
          end
        end
        mdrp_pkg::MDRP_PRE:
        begin
          cnt <= cnt + 4'h1;
          if (cnt >= 4'(mdrp_pkg::PRECHARGE_CYC - 1))
          begin
            if (desel_due)
            begin
              // column-only pulse with row strobe high clears a held output
              ram_cas_n_out <= 1'b0;
              desel_due     <= 1'b0;
              state         <= mdrp_pkg::MDRP_DESEL;
            end
            else
              state <= mdrp_pkg::MDRP_IDLE;
          end
        end
        mdrp_pkg::MDRP_DESEL:
        begin
          ram_cas_n_out <= 1'b1;
          state         <= mdrp_pkg::MDRP_IDLE;
        end
        default:
          state <= mdrp_pkg::MDRP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strobe timing checks
  // ---------------------------------------------------------------
  // counts match the 20 MHz defaults: two precharge, three active cycles
  a_precharge_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(ram_ras_n_out) |-> ram_ras_n_out [*2])
    else $error("row strobe high shorter than precharge");

  a_row_active_min: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(ram_ras_n_out) |-> !ram_ras_n_out [*3])
    else $error("row strobe low shorter than active minimum");

  // one cycle after the fall: the address seen at the fall edge and one edge later must match,
  // the column half legally replaces it on the following edge
  a_row_addr_stable: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(ram_ras_n_out) |-> $stable(ram_addr_out))
    else $error("row address moved around row strobe fall");

  a_col_after_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(ram_cas_n_out) && !ram_ras_n_out |->
      $stable(ram_addr_out) && $past(ram_ras_n_out, 2) == 1'b0 && $past(ram_ras_n_out, 3) == 1'b1)
    else $error("column strobe fell outside the multiplex slot");

  a_write_setup: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(ram_cas_n_out) && !ram_ras_n_out |-> $stable(ram_we_n_out) && $stable(ram_din_out))
    else $error("write strobe or data changed at column strobe fall");

  a_read_sample: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_valid_out |-> $past(ram_cas_n_out) == 1'b0 && $past(ram_cas_n_out, 2) == 1'b0
                     && ram_cas_n_out && ram_ras_n_out)
    else $error("read data taken before column access elapsed");

  a_cbr_only_variant: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(ram_ras_n_out) && !ram_cas_n_out |-> CBR_REFRESH && ram_we_n_out ##1 !ram_cas_n_out)
    else $error("column strobe low at row fall outside refresh variant");

  a_strobes_rise: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(ram_cas_n_out) && $past(ram_ras_n_out) == 1'b0 |-> $rose(ram_ras_n_out) && ram_we_n_out)
    else $error("strobes did not rise together at end of access");

endmodule

`default_nettype wire

/* dv/mdrp_mem_model.sv */
/*
  Behavioural 16384 x 1 dynamic memory with a count of timing breaches.
  Assumes strobes and address come from a registered controller.
*/
`default_nettype none

module mdrp_mem_model #(
  parameter int RET_NS   = 104400,
  parameter bit CBR      = 1'b0,
  parameter bit REL_FALL = 1'b0
) (
  input  wire logic       ras_n_in,
  input  wire logic       cas_n_in,
  input  wire logic       we_n_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       din_in,
  output var  logic       dout_out,
  output var  int         viol_out,
  output var  int         ref_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        cells [16384];
  logic [6:0]  row;
  logic [13:0] a;
  logic        ref_only;
  realtime     t_rise;
  realtime     t_fall;
  realtime     seen [128];

  // empty array, nothing aged yet
  initial
  begin
    foreach (cells[i]) cells[i] = 1'b0;
    foreach (seen[i]) seen[i] = 0;
    {dout_out, ref_only, row} = '0;
    viol_out = 0;
    ref_out = 0;
    t_rise = 0;
    t_fall = -1000.0; // strobe leaving unknown at reset is no short active time
  end

  // row fall: latch row, age every row, mark what opens
  always @(negedge ras_n_in)
  begin
    if ($realtime - t_rise < 100) viol_out++;
    t_fall = $realtime;
    ref_only = CBR && !cas_n_in;
    row = addr_in;
    ref_out += CBR ? int'(ref_only) : 1;
    for (int r = 0; r < 128; r++)
    begin
      if ($realtime - seen[r] > RET_NS) viol_out++;
      if (r[6:0] == row || (ref_only && r[5:0] == row[5:0])) seen[r] = $realtime;
    end
  end

  // row rise: minimum active time
  always @(posedge ras_n_in)
  begin
    if ($realtime - t_fall < 150) viol_out++;
    t_rise = $realtime;
  end

  // column fall: no upper limit on the delay, late is only slower
  always @(negedge cas_n_in)
  begin
    if (REL_FALL) dout_out = ~dout_out;
    a = {row, addr_in};
    if (!ras_n_in && !ref_only)
    begin
      if ($realtime - t_fall < 25) viol_out++;
      if (!we_n_in) cells[a] = din_in;
      else
      begin
        dout_out = ~cells[a];
        #99 if (!cas_n_in) dout_out = cells[a];
      end
    end
  end

  // released output shows the inverse, never a kind stale bit
  always @(posedge cas_n_in)
    if (!REL_FALL) dout_out = ~dout_out;

  // address moves only after row hold, never under both strobes
  always @(addr_in)
  begin
    #0.1;
    if (!ras_n_in && (!cas_n_in || $realtime - t_fall < 25)) viol_out++;
  end
endmodule

`default_nettype wire

/* dv/tb.sv */
/*
  Bench: one controller per variant, each on its own memory model.
  Assumes the design package and sources are compiled first.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RET = 102400; // 16-cycle refresh interval on pair 0, 32-cycle on pair 1 (column-low refresh)
  localparam logic [13:0] ADR [6] = '{14'h0000, 14'h3fff, 14'h2a55, 14'h1580, 14'h007f, 14'h3f80};
  logic        clk_in;
  logic        srst_in;
  logic        valid [2], wr [2], wd [2], rdy [2], rdv [2], rdd [2];
  logic        ras_n [2], cas_n [2], we_n [2], din [2], dout [2];
  logic [13:0] ad [2];
  logic [6:0]  ma [2];
  int          viol [2], refs [2];
  int          bad_count;
  int          checked;

  // --------
  // clock and pairs
  // --------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  for (genvar g = 0; g < 2; g++)
  begin : gi
    // pair 1: refresh with column low, release on column fall
    mdrp_ctrl #(.RETENTION_NS(RET), .CBR_REFRESH(g == 1), .RELEASE_ON_FALL(g == 1)) dut (
      .clk_in(clk_in), .srst_in(srst_in), .req_valid_in(valid[g]), .req_write_in(wr[g]),
      .req_addr_in(ad[g]), .req_wdata_in(wd[g]), .req_ready_out(rdy[g]), .rd_valid_out(rdv[g]),
      .rd_data_out(rdd[g]), .ram_ras_n_out(ras_n[g]), .ram_cas_n_out(cas_n[g]),
      .ram_we_n_out(we_n[g]), .ram_addr_out(ma[g]), .ram_din_out(din[g]), .ram_dout_in(dout[g]));
    // margin: a refresh may wait behind one access
    mdrp_mem_model #(.RET_NS(RET + 2000), .CBR(g == 1), .REL_FALL(g == 1)) mem (
      .ras_n_in(ras_n[g]), .cas_n_in(cas_n[g]), .we_n_in(we_n[g]), .addr_in(ma[g]),
      .din_in(din[g]), .dout_out(dout[g]), .viol_out(viol[g]), .ref_out(refs[g]));
  end

  // --------
  // helpers
  // --------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // inputs move 1 ns after the edge
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  // cycles until ready or read valid shows, bounded
  task automatic await(input int k, input bit rd, output int n);
    for (n = 0; (rd ? rdv[k] : rdy[k]) !== 1'b1; n++)
    begin
      if (n == 80)
      begin
        bad_count++;
        wrap_up();
      end
      tick();
    end
  endtask

  function automatic logic peek(input int k, input logic [13:0] a);
    return (k == 0) ? gi[0].mem.cells[a] : gi[1].mem.cells[a];
  endfunction

  // one request; a read is judged on data, latency and release
  task automatic access(input int k, input logic w, input logic [13:0] a, input logic d);
    int n;
    valid[k] = 1'b1;
    wr[k] = w;
    ad[k] = a;
    wd[k] = d;
    await(k, 1'b0, n);
    tick();
    valid[k] = 1'b0;
    tick();
    if (!w)
    begin
      await(k, 1'b1, n);
      check(n, 4);
      check(rdd[k], d);
      check({ras_n[k], cas_n[k]}, 2'h3);
      if (k == 1)
      begin
        tick();
        tick();
        check({ras_n[k], cas_n[k]}, 2'h2);
      end
    end
  endtask

  // --------
  // scenarios
  // --------
  // reset parks strobes high and closes the port
  task automatic s_reset();
    srst_in = 1'b1;
    tick();
    tick();
    for (int k = 0; k < 2; k++)
    begin
      check({ras_n[k], cas_n[k], we_n[k], rdy[k], rdv[k], rdd[k], din[k]}, 7'h70);
      check(ma[k], 7'h00);
    end
    srst_in = 1'b0;
  endtask

  // corner addresses: writes, backdoor look, read back
  task automatic s_data(input int k, input logic f);
    for (int i = 0; i < 6; i++) access(k, 1'b1, ADR[i], ^ADR[i] ^ f);
    repeat (8) tick();
    for (int i = 0; i < 6; i++) check(peek(k, ADR[i]), ^ADR[i] ^ f);
    for (int i = 0; i < 6; i++) access(k, 1'b0, ADR[i], ^ADR[i] ^ f);
  endtask

  // long idle: refresh alone keeps every row within retention, and the six corner addresses still read back
  task automatic s_idle(input int k, input logic f);
    int r0;
    r0 = refs[k];
    repeat (5000) tick();
    check(refs[k] - r0 > 200 / (k + 1), 1'b1);
    check(viol[k], 0);
    for (int i = 0; i < 6; i++) access(k, 1'b0, ADR[i], ^ADR[i] ^ f);
  endtask

  initial
  begin
    bad_count = 0;
    checked = 0;
    for (int k = 0; k < 2; k++)
    begin
      valid[k] = 1'b0;
      wr[k] = 1'b0;
      wd[k] = 1'b0;
      ad[k] = 14'h0000;
    end
    s_reset();
    s_data(0, 1'b0);
    s_data(1, 1'b1);
    s_idle(0, 1'b0);
    s_idle(1, 1'b1);
    // second reset mid-run, then fresh traffic
    s_reset();
    s_data(0, 1'b1);
    s_data(1, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
